// ---- rtl/spbt_decoder.sv ----
// bit timing decoder for the shared mode/serial pin
// assumes the pin input is already synchronous to i_clk_sys
`timescale 1ns/100ps
`include "spbt_defs.svh"

module spbt_decoder #(
   parameter int unsigned PHASE_MIN = `SPBT_PHASE_MIN_CYC,
   parameter int unsigned PHASE_MAX = `SPBT_PHASE_MAX_CYC,
   parameter int unsigned ACK_CYC   = `SPBT_ACK_CYC,
   parameter int unsigned SAVE_CYC  = `SPBT_SAVE_CYC
) (
   // clock and reset
   input  wire logic                i_clk_sys,
   input  wire logic                i_arst_n,
   // serial pin
   input  wire logic                i_line,
   output spbt_pkg::spbt_pin_type   o_line,
   // frame logic side
   input  wire logic                i_ack_req,
   output spbt_pkg::spbt_bit_type   o_bit,
   // mode
   output logic                     o_power_save,
   output logic                     o_forced_pwm
);
   import spbt_pkg::*;

   localparam int W = `SPBT_CNT_W;

   // ----------------------------------------
   // state
   // ----------------------------------------
   spbt_state_type         state_q, state_d;
   logic [W-1:0]           first_q, first_d;   // length of first phase
   logic [W-1:0]           cnt_q, cnt_d;       // current phase length
   logic                   open_q, open_d;     // a first phase waits for its pair
   logic                   line_edge;          // pin level differs from last sample
   logic                   line_q;
   spbt_bit_type           bit_q, bit_d;
   spbt_pin_type           pin_q, pin_d;
   logic [W-1:0]           low_q, low_d;       // low time since last fall
   logic                   save_q, save_d;
   logic                   pwm_q, pwm_d;
   logic [W-1:0]           high_q, high_d;     // static high time

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // one decode per two phases; the ratio test is done at the phase edge.
   // every finished phase is tried first as the second half of an open
   // pair; if that fails it may open a new pair itself. this sliding view
   // means an idle high longer than half the following low cannot swallow a one bit.
   always_comb begin
      state_d   = state_q;
      first_d   = first_q;
      cnt_d     = cnt_q;
      open_d    = open_q;
      bit_d     = '0;
      pin_d     = pin_q;
      line_edge = (i_line != line_q);
      case (state_q)
         SPBT_IDLE, SPBT_LOW, SPBT_HIGH: begin
            // phase length, saturates so a long idle never wraps
            if (cnt_q != {W{1'b1}}) begin
               cnt_d = cnt_q + W'(1);
            end
            if (line_edge) begin
               // the edge cycle itself counts as the first cycle of the phase
               cnt_d   = W'(1);
               state_d = i_line ? SPBT_HIGH : SPBT_LOW;
               if (open_q && cnt_q >= {first_q[W-2:0], 1'b0}
                   && cnt_q <= W'(PHASE_MAX)) begin
                  // long low after high decodes zero
                  // long high after low decodes one
                  bit_d  = '{valid: 1'b1, value: line_q};
                  open_d = 1'b0;
               end else if (cnt_q >= W'(PHASE_MIN)
                            && cnt_q <= W'(PHASE_MAX / 2)) begin
                  // first phase 2..200 us opens a pair
                  open_d  = 1'b1;
                  first_d = cnt_q;
               end else begin
                  // too short or too long to start a bit
                  open_d = 1'b0;
               end
            end else if (cnt_q > W'(PHASE_MAX)) begin
               // long static level ends the stream
               state_d = SPBT_IDLE;
               open_d  = 1'b0;
            end
            // frame logic may ask for an acknowledge in any state but SPBT_ACK
            if (i_ack_req) begin
               state_d = SPBT_ACK;
               pin_d   = '{out: 1'b0, oe: 1'b1};
               cnt_d   = '0;
               open_d  = 1'b0;
            end
         end
         SPBT_ACK: begin
            // hold low for fixed ack length
            cnt_d = cnt_q + W'(1);
            if (cnt_q >= W'(ACK_CYC - 1)) begin
               pin_d   = '{out: 1'b0, oe: 1'b0};
               state_d = SPBT_IDLE;
               cnt_d   = '0;
            end
         end
         default: begin
            state_d = SPBT_IDLE;
            pin_d   = '{out: 1'b0, oe: 1'b0};
         end
      endcase
   end

   // ----------------------------------------
   // mode tracking
   // ----------------------------------------
   // own ack low does not count as host low, or an ack would
   // eventually look like a request for power save
   always_comb begin
      low_d  = '0;
      high_d = '0;
      save_d = save_q;
      pwm_d  = pwm_q;
      if (!i_line && !pin_q.oe) begin
         low_d = (low_q == {W{1'b1}}) ? low_q : low_q + W'(1);
         if (low_q >= W'(SAVE_CYC - 1)) begin
            save_d = 1'b1;
            pwm_d  = 1'b0;
         end
      end
      if (i_line) begin
         high_d = (high_q == {W{1'b1}}) ? high_q : high_q + W'(1);
         if (high_q >= W'(PHASE_MAX)) begin
            pwm_d  = 1'b1;
            save_d = 1'b0;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q    <= SPBT_IDLE;
         first_q    <= '0;
         cnt_q      <= '0;
         open_q     <= 1'b0;
         line_q     <= 1'b1;
         bit_q      <= '0;
         pin_q      <= '0;
         low_q      <= '0;
         high_q     <= '0;
         save_q     <= 1'b1;   // light-load default until a static high forces PWM
         pwm_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         first_q    <= first_d;
         cnt_q      <= cnt_d;
         open_q     <= open_d;
         line_q     <= i_line;
         bit_q      <= bit_d;
         pin_q      <= pin_d;
         low_q      <= low_d;
         high_q     <= high_d;
         save_q     <= save_d;
         pwm_q      <= pwm_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // outputs straight from flops, no logic after the registers
   assign o_line       = pin_q;
   assign o_bit        = bit_q;
   assign o_power_save = save_q;
   assign o_forced_pwm = pwm_q;

endmodule : spbt_decoder

// ---- rtl/spbt_defs.svh ----
// timing constants for the one-pin serial bit decoder
// assumes a 40 MHz system clock; every count is derived from a time in ns
//
// Notes on behaviour
// - low at least twice high decodes zero
// - high at least twice low decodes one
// - acknowledge low 400..520 us, valid within 2 us
// - acknowledge only sinks line, open drain
// - power save within 520 us of fall
// - static high line forces fixed PWM
`ifndef SPBT_DEFS_SVH
`define SPBT_DEFS_SVH

`define SPBT_CLK_PERIOD_NS      25
// least phase time, rounds up
`define SPBT_PHASE_MIN_NS       2000
`define SPBT_PHASE_MIN_CYC      ((`SPBT_PHASE_MIN_NS + `SPBT_CLK_PERIOD_NS - 1) / `SPBT_CLK_PERIOD_NS)
// longest second phase, rounds down
`define SPBT_PHASE_MAX_NS       400000
`define SPBT_PHASE_MAX_CYC      (`SPBT_PHASE_MAX_NS / `SPBT_CLK_PERIOD_NS)
// acknowledge length, target inside 400..520 us
`define SPBT_ACK_NS             460000
`define SPBT_ACK_CYC            (`SPBT_ACK_NS / `SPBT_CLK_PERIOD_NS)
// power save timeout, inside 520 us, rounds down; entered as it runs out
`define SPBT_SAVE_NS            500000
`define SPBT_SAVE_CYC           (`SPBT_SAVE_NS / `SPBT_CLK_PERIOD_NS)
// counter width covers the largest count
`define SPBT_CNT_W              15

`endif

// ---- rtl/spbt_pkg.sv ----
// types shared by the one-pin serial bit decoder
// assumes nothing beyond the defs header
package spbt_pkg;

   // receive state machine
   typedef enum logic [1:0] {
      SPBT_IDLE = 2'b00,
      SPBT_HIGH = 2'b01,
      SPBT_LOW  = 2'b10,
      SPBT_ACK  = 2'b11
   } spbt_state_type;

   // decoded bit as handed to frame logic
   typedef struct packed {
      logic valid;
      logic value;
   } spbt_bit_type;

   // open-drain pin: level and enable
   typedef struct packed {
      logic out;
      logic oe;
   } spbt_pin_type;

endpackage : spbt_pkg

// ---- test/spbt_decoder_asserts.sv ----
// port checker for the serial bit decoder
// assumes host phases on the line stay within the timing limits
`timescale 1ns/100ps
module spbt_decoder_asserts #(
   parameter int unsigned PHASE_MAX = 40,
   parameter int unsigned ACK_CYC   = 50,
   parameter int unsigned SAVE_CYC  = 60
) (
   input wire logic              i_clk_sys,
   input wire logic              i_arst_n,
   input wire logic              i_line,
   input spbt_pkg::spbt_pin_type o_line,
   input wire logic              i_ack_req,
   input spbt_pkg::spbt_bit_type o_bit,
   input wire logic              o_power_save,
   input wire logic              o_forced_pwm
);
   logic [15:0] oe_q, lo_q, hi_q;
   // run lengths of ack, line low and line high
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
      if (!i_arst_n) {oe_q, lo_q, hi_q} <= '0;
      else begin
         oe_q <= o_line.oe ? oe_q + 16'h0001 : 16'h0000;
         lo_q <= i_line ? 16'h0000 : lo_q + 16'h0001;
         hi_q <= i_line ? hi_q + 16'h0001 : 16'h0000;
      end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   chk_out_low: assert property (o_line.out == 1'b0) else $error("pin high");
   chk_ack_rise: assert property (i_ack_req && !o_line.oe |=> o_line.oe)
      else $error("ack late");
   chk_ack_len: assert property ($fell(o_line.oe) |-> oe_q == ACK_CYC)
      else $error("ack length");
   chk_bit_edge: assert property (o_bit.valid |-> $past(i_line) != $past(i_line, 2)
      && o_bit.value == !$past(i_line)) else $error("bit value");
   chk_bit_pulse: assert property (o_bit.valid |=> !o_bit.valid) else $error("pulse");
   chk_save_late: assert property (lo_q >= SAVE_CYC + 3 |-> o_power_save)
      else $error("save late");
   chk_pwm_high: assert property (hi_q >= PHASE_MAX + 3 |-> o_forced_pwm && !o_power_save)
      else $error("no pwm");
   cov_one: cover property (o_bit.valid && o_bit.value);
   cov_zero: cover property (o_bit.valid && !o_bit.value);
   cov_ack: cover property ($rose(o_line.oe));
endmodule : spbt_decoder_asserts
bind spbt_decoder spbt_decoder_asserts #(.PHASE_MAX(PHASE_MAX), .ACK_CYC(ACK_CYC),
   .SAVE_CYC(SAVE_CYC)) u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_line(i_line),
   .o_line(o_line), .i_ack_req(i_ack_req), .o_bit(o_bit), .o_power_save(o_power_save),
   .o_forced_pwm(o_forced_pwm));

// ---- test/spbt_host_model.sv ----
// host on the serial line, sinking it through open drain
// assumes an external pull-up; called just after a clock edge
`timescale 1ns/100ps
module spbt_host_model (
   // clock
   input  wire logic i_clk_sys,
   // high pulls the line low
   output logic      o_drive_low
);
   initial o_drive_low = 1'b0;
   // level high releases the line for the device ack
   task automatic phase(input logic lvl, input int cyc);
      o_drive_low <= !lvl;
      repeat (cyc) @(posedge i_clk_sys);
   endtask : phase
endmodule : spbt_host_model

// ---- test/test_spbt_decoder.sv ----
// bench for the serial bit decoder with a host model on the line
// assumes shortened timing parameters to keep the run brief
`timescale 1ns/100ps
module test_spbt_decoder;
   import spbt_pkg::*;
   logic clk, arst_n, ack_req, host_low, got, val, power_save, forced_pwm;
   spbt_pin_type pin;
   spbt_bit_type dbit;
   int bad_count = 0, checks_done = 0, n;
   wire line = !(host_low | pin.oe);
   spbt_decoder #(.PHASE_MIN(4), .PHASE_MAX(40), .ACK_CYC(50), .SAVE_CYC(60)) u_spbt_decoder (
      .i_clk_sys(clk), .i_arst_n(arst_n), .i_line(line), .o_line(pin), .i_ack_req(ack_req),
      .o_bit(dbit), .o_power_save(power_save), .o_forced_pwm(forced_pwm));
   spbt_host_model u_spbt_host_model (.i_clk_sys(clk), .o_drive_low(host_low));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic ph(input logic lvl, input int cyc);
      u_spbt_host_model.phase(lvl, cyc);
   endtask : ph
   // watch five cycles for a decoded bit, latency left open
   task automatic see_bit();
      got = 1'b0;
      repeat (5) begin
         #1;
         if (dbit.valid === 1'b1) {got, val} = {1'b1, dbit.value};
         @(posedge clk);
      end
   endtask : see_bit
   task automatic t_one();
      ph(1'b1, 8);
      ph(1'b0, 5);
      ph(1'b1, 12);
      ph(1'b0, 0);
      see_bit();
      check({got, val}, 8'h03);
      // high shorter than twice the low is refused
      ph(1'b1, 7);
      ph(1'b0, 0);
      see_bit();
      check(got, 8'h00);
   endtask : t_one
   task automatic t_modes();
      ph(1'b1, 45);
      check(forced_pwm, 8'h01);
      ph(1'b0, 65);
      check(power_save, 8'h01);
   endtask : t_modes
   task automatic t_zero();
      ph(1'b1, 5);
      ph(1'b0, 12);
      ph(1'b1, 0);
      see_bit();
      check({got, val}, 8'h02);
   endtask : t_zero
   task automatic t_ack();
      ph(1'b1, 10);
      ack_req <= 1'b1;
      @(posedge clk);
      ack_req <= 1'b0;
      n = 0;
      repeat (100) begin
         #1;
         if (pin.oe === 1'b1) n++;
         if (pin.oe === 1'b1) check(line, 8'h00);
         @(posedge clk);
      end
      check(8'(n), 8'h32);
   endtask : t_ack
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // cut a hang short, run needs a few hundred cycles
   initial begin
      #50000;
      bad_count++;
      give_verdict();
   end
   initial begin
      arst_n = 1'b0;
      ack_req = 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      check(power_save, 8'h01);
      check(forced_pwm, 8'h00);
      t_one();
      t_modes();
      t_zero();
      t_ack();
      give_verdict();
   end
endmodule : test_spbt_decoder
